// File: rtl/dpsr_top.sv
// Summary of operation
// - DAC register bits 7:4 pick DAC channel 1 source, reset 0x1.
// - DAC register bits 3:0 pick DAC channel 0 source, reset 0x0.
// - New DAC selects take effect only while core run enable is low.
// - PDM register bits 7:4 pick PDM channel 1 source, reset 0x3.
// - PDM register bits 3:0 pick PDM channel 0 source, reset 0x2.
// - PDM register lives at 0x12, read/write, resets to 0x32.
`timescale 1ns/1ps
`include "dpsr_regs.svh"

module dpsr_top #(
   parameter int SAMPLE_W = 24
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [7:0] regRdData,
   input wire logic coreRunEnable,
   input wire logic [SAMPLE_W-1:0] coreOut0,
   input wire logic [SAMPLE_W-1:0] coreOut1,
   input wire logic [SAMPLE_W-1:0] coreOut2,
   input wire logic [SAMPLE_W-1:0] coreOut3,
   input wire logic [SAMPLE_W-1:0] asrcIn0,
   input wire logic [SAMPLE_W-1:0] asrcIn1,
   input wire logic coreOut0Valid,
   input wire logic coreOut1Valid,
   input wire logic coreOut2Valid,
   input wire logic coreOut3Valid,
   input wire logic asrcIn0Valid,
   input wire logic asrcIn1Valid,
   output logic [SAMPLE_W-1:0] dac0Sample,
   output logic dac0Valid,
   output logic [SAMPLE_W-1:0] dac1Sample,
   output logic dac1Valid,
   output logic [SAMPLE_W-1:0] pdm0Sample,
   output logic pdm0Valid,
   output logic [SAMPLE_W-1:0] pdm1Sample,
   output logic pdm1Valid,
   output logic [3:0] badSelect,
   output logic dacRoutePending
);

   dpsr_pkg::dpsr_reg_t dacStored;
   dpsr_pkg::dpsr_reg_t dacEffective;
   dpsr_pkg::dpsr_reg_t pdmStored;
   dpsr_pkg::dpsr_reg_t pdmEffective;
   logic dacWrite;
   logic pdmWrite;
   logic [6*SAMPLE_W-1:0] srcData;
   logic [5:0] srcValid;
   logic [7:0] next_regRdData;
   logic next_dacRoutePending;

   // Field extraction shared by all four channel selects.
   function automatic dpsr_pkg::dpsr_sel_t fieldOf(
      input dpsr_pkg::dpsr_reg_t value,
      input bit upper
   );
      if (upper) begin
         fieldOf = value[`DPSR_CH1_LSB +: `DPSR_FIELD_W];
      end else begin
         fieldOf = value[`DPSR_CH0_LSB +: `DPSR_FIELD_W];
      end
   endfunction

   assign dacWrite = regWrite && (regAddr == `DPSR_DAC_ROUTE_ADDR);
   assign pdmWrite = regWrite && (regAddr == `DPSR_PDM_ROUTE_ADDR);

   // Slot order must match the slot numbers in the source mux.
   assign srcData = {asrcIn1, asrcIn0, coreOut3, coreOut2, coreOut1, coreOut0};
   assign srcValid = {asrcIn1Valid, asrcIn0Valid, coreOut3Valid,
                      coreOut2Valid, coreOut1Valid, coreOut0Valid};

   // The DAC register keeps software's value readable at once, but the
   // selection that reaches the DACs is frozen while the core executes, so
   // a careless write cannot switch sources mid-stream.
   dpsr_route_reg #(
      .RESET_VAL(`DPSR_DAC_ROUTE_RESET),
      .GATED(1'b1)
   ) dacRoute (
      .ref_clk(ref_clk),
      .reset(reset),
      .wrEn(dacWrite),
      .wrData(regWrData),
      .hold(coreRunEnable),
      .stored(dacStored),
      .effective(dacEffective)
   );

   dpsr_route_reg #(
      .RESET_VAL(`DPSR_PDM_ROUTE_RESET),
      .GATED(1'b0)
   ) pdmRoute (
      .ref_clk(ref_clk),
      .reset(reset),
      .wrEn(pdmWrite),
      .wrData(regWrData),
      .hold(1'b0),
      .stored(pdmStored),
      .effective(pdmEffective)
   );

   dpsr_source_mux #(
      .SAMPLE_W(SAMPLE_W)
   ) dac0Mux (
      .ref_clk(ref_clk),
      .reset(reset),
      .sel(fieldOf(dacEffective, 1'b0)),
      .srcData(srcData),
      .srcValid(srcValid),
      .outData(dac0Sample),
      .outValid(dac0Valid),
      .badSelect(badSelect[0])
   );

   dpsr_source_mux #(
      .SAMPLE_W(SAMPLE_W)
   ) dac1Mux (
      .ref_clk(ref_clk),
      .reset(reset),
      .sel(fieldOf(dacEffective, 1'b1)),
      .srcData(srcData),
      .srcValid(srcValid),
      .outData(dac1Sample),
      .outValid(dac1Valid),
      .badSelect(badSelect[1])
   );

   dpsr_source_mux #(
      .SAMPLE_W(SAMPLE_W)
   ) pdm0Mux (
      .ref_clk(ref_clk),
      .reset(reset),
      .sel(fieldOf(pdmEffective, 1'b0)),
      .srcData(srcData),
      .srcValid(srcValid),
      .outData(pdm0Sample),
      .outValid(pdm0Valid),
      .badSelect(badSelect[2])
   );

   dpsr_source_mux #(
      .SAMPLE_W(SAMPLE_W)
   ) pdm1Mux (
      .ref_clk(ref_clk),
      .reset(reset),
      .sel(fieldOf(pdmEffective, 1'b1)),
      .srcData(srcData),
      .srcValid(srcValid),
      .outData(pdm1Sample),
      .outValid(pdm1Valid),
      .badSelect(badSelect[3])
   );

   // Read data stands only in the cycle after the strobe and is zero
   // otherwise, so a stale value can never be mistaken for an answer.
   always_comb begin
      next_regRdData = 8'h00;
      if (regRead) begin
         if (regAddr == `DPSR_DAC_ROUTE_ADDR) begin
            next_regRdData = dacStored;
         end else if (regAddr == `DPSR_PDM_ROUTE_ADDR) begin
            next_regRdData = pdmStored;
         end else begin
            next_regRdData = `DPSR_UNMAPPED_READ;
         end
      end
      next_dacRoutePending = (dacStored != dacEffective) || (dacWrite && coreRunEnable
                             && (regWrData != dacEffective));
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         regRdData <= 8'h00;
         dacRoutePending <= 1'b0;
      end else begin
         regRdData <= next_regRdData;
         dacRoutePending <= next_dacRoutePending;
      end
   end

endmodule

// File: rtl/dpsr_regs.svh
`ifndef DPSR_REGS_SVH
`define DPSR_REGS_SVH

// Register addresses.
`define DPSR_DAC_ROUTE_ADDR 8'h11
`define DPSR_PDM_ROUTE_ADDR 8'h12

// Reset values.
`define DPSR_DAC_ROUTE_RESET 8'h10
`define DPSR_PDM_ROUTE_RESET 8'h32

// Field positions inside each routing register.
`define DPSR_CH1_LSB 4
`define DPSR_CH0_LSB 0
`define DPSR_FIELD_W 4

// Source select codes.
`define DPSR_SRC_CORE0 4'h0
`define DPSR_SRC_CORE1 4'h1
`define DPSR_SRC_CORE2 4'h2
`define DPSR_SRC_CORE3 4'h3
`define DPSR_SRC_ASRC0 4'hC
`define DPSR_SRC_ASRC1 4'hD

// Value returned on an unmapped read.
`define DPSR_UNMAPPED_READ 8'h00

`endif

// File: rtl/dpsr_pkg.sv
package dpsr_pkg;

   typedef logic [3:0] dpsr_sel_t;
   typedef logic [7:0] dpsr_reg_t;

endpackage

// File: rtl/dpsr_route_reg.sv
`timescale 1ns/1ps
`include "dpsr_regs.svh"

// One 8-bit routing register. The stored value is what software reads back.
// The effective value drives the source muxes; when GATED is set it only
// follows the stored value while the hold input is low.
module dpsr_route_reg #(
   parameter dpsr_pkg::dpsr_reg_t RESET_VAL = 8'h00,
   parameter bit GATED = 1'b0
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic wrEn,
   input wire dpsr_pkg::dpsr_reg_t wrData,
   input wire logic hold,
   output dpsr_pkg::dpsr_reg_t stored,
   output dpsr_pkg::dpsr_reg_t effective
);

   dpsr_pkg::dpsr_reg_t next_stored;
   dpsr_pkg::dpsr_reg_t next_effective;

   always_comb begin
      next_stored = wrEn ? wrData : stored;
      // A write made while held stays pending and lands when the hold drops.
      if (GATED && hold) begin
         next_effective = effective;
      end else begin
         next_effective = next_stored;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         stored <= RESET_VAL;
         effective <= RESET_VAL;
      end else begin
         stored <= next_stored;
         effective <= next_effective;
      end
   end

endmodule

// File: rtl/dpsr_source_mux.sv
`timescale 1ns/1ps
`include "dpsr_regs.svh"

// Registered six-way sample selector for one output channel.
module dpsr_source_mux #(
   parameter int SAMPLE_W = 24
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire dpsr_pkg::dpsr_sel_t sel,
   input wire logic [6*SAMPLE_W-1:0] srcData,
   input wire logic [5:0] srcValid,
   output logic [SAMPLE_W-1:0] outData,
   output logic outValid,
   output logic badSelect
);

   logic [SAMPLE_W-1:0] next_outData;
   logic next_outValid;
   logic next_badSelect;

   // Maps a select code to a source slot; slot 6 means no source.
   function automatic logic [2:0] slotOf(input dpsr_pkg::dpsr_sel_t code);
      unique case (code)
         `DPSR_SRC_CORE0: slotOf = 3'h0;
         `DPSR_SRC_CORE1: slotOf = 3'h1;
         `DPSR_SRC_CORE2: slotOf = 3'h2;
         `DPSR_SRC_CORE3: slotOf = 3'h3;
         `DPSR_SRC_ASRC0: slotOf = 3'h4;
         `DPSR_SRC_ASRC1: slotOf = 3'h5;
         default: slotOf = 3'h6;
      endcase
   endfunction

   always_comb begin
      logic [2:0] slot;
      slot = slotOf(sel);
      // Reserved codes feed silence rather than an arbitrary source.
      if (slot == 3'h6) begin
         next_outData = '0;
         next_outValid = 1'b0;
         next_badSelect = 1'b1;
      end else begin
         next_outData = srcData[slot*SAMPLE_W +: SAMPLE_W];
         next_outValid = srcValid[slot];
         next_badSelect = 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         outData <= '0;
         outValid <= 1'b0;
         badSelect <= 1'b0;
      end else begin
         outData <= next_outData;
         outValid <= next_outValid;
         badSelect <= next_badSelect;
      end
   end

endmodule

// File: test/dpsr_route_monitor.sv
`timescale 1ns/1ps
module dpsr_route_monitor #(
   parameter int SAMPLE_W = 24
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [7:0] regRdData,
   input wire logic coreRunEnable,
   input wire logic [SAMPLE_W-1:0] coreOut0,
   input wire logic [SAMPLE_W-1:0] asrcIn0,
   input wire logic [SAMPLE_W-1:0] pdm0Sample,
   input wire logic [SAMPLE_W-1:0] pdm1Sample,
   input wire logic [3:0] badSelect,
   input wire logic dacRoutePending
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (reset);
   property p_rdIdle; !$past(regRead) |-> regRdData == 8'h00; endproperty
   a_rdIdle: assert property (p_rdIdle) else $error("read data lingers");
   property p_unmap; regRead && regAddr != 8'h11 && regAddr != 8'h12 |=> regRdData == 8'h00;
   endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read");
   property p_back; regWrite && regAddr == 8'h12 ##1 regRead && regAddr == 8'h12
      |=> regRdData == $past(regWrData, 2); endproperty
   a_back: assert property (p_back) else $error("readback");
   property p_pdm0; regWrite && regAddr == 8'h12 && regWrData[3:0] == 4'h0
      |=> ##1 pdm0Sample == $past(coreOut0); endproperty
   a_pdm0: assert property (p_pdm0) else $error("pdm0 route");
   property p_pdm1; regWrite && regAddr == 8'h12 && regWrData[7:4] == 4'hC
      |=> ##1 pdm1Sample == $past(asrcIn0); endproperty
   a_pdm1: assert property (p_pdm1) else $error("pdm1 route");
   property p_bad; regWrite && regAddr == 8'h12 && regWrData[3:0] > 4'hD |=> ##1 badSelect[2];
   endproperty
   a_bad: assert property (p_bad) else $error("reserved code");
   // A write while running must stay parked until the core halts.
   // Two quiet running cycles are needed, since the flag trails the applied value by one edge.
   property p_hold; dacRoutePending && coreRunEnable && $past(coreRunEnable) && !regWrite
      && !$past(regWrite) |=> dacRoutePending; endproperty
   a_hold: assert property (p_hold) else $error("pending lost");
   property p_clear; (!coreRunEnable && !regWrite) [*3] |-> !dacRoutePending; endproperty
   a_clear: assert property (p_clear) else $error("pending stuck");
endmodule
bind dpsr_top dpsr_route_monitor #(.SAMPLE_W(SAMPLE_W)) u_mon (.ref_clk(ref_clk),
   .reset(reset), .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
   .regRead(regRead), .regRdData(regRdData), .coreRunEnable(coreRunEnable),
   .coreOut0(coreOut0), .asrcIn0(asrcIn0), .pdm0Sample(pdm0Sample),
   .pdm1Sample(pdm1Sample), .badSelect(badSelect), .dacRoutePending(dacRoutePending));

// File: test/test_dac_pdm_source_routing.sv
`timescale 1ns/1ps
module test_dac_pdm_source_routing;
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   logic regWrite = 1'b0;
   logic regRead = 1'b0;
   logic coreRunEnable = 1'b0;
   logic [7:0] regAddr = 8'h00;
   logic [7:0] regWrData = 8'h00;
   logic [5:0] srcV = 6'h2D;
   logic [23:0] src [6];
   logic [3:0] codes [6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'hC, 4'hD};
   logic [7:0] regRdData;
   logic [23:0] dac0Sample, dac1Sample, pdm0Sample, pdm1Sample;
   logic dac0Valid, dac1Valid, pdm0Valid, pdm1Valid, dacRoutePending;
   logic [3:0] badSelect;
   int n_fail = 0;
   int checks = 0;
   dpsr_top #(.SAMPLE_W(24)) u_dut (.ref_clk(ref_clk), .reset(reset), .regAddr(regAddr),
      .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
      .coreRunEnable(coreRunEnable), .coreOut0(src[0]), .coreOut1(src[1]), .coreOut2(src[2]),
      .coreOut3(src[3]), .asrcIn0(src[4]), .asrcIn1(src[5]), .coreOut0Valid(srcV[0]),
      .coreOut1Valid(srcV[1]), .coreOut2Valid(srcV[2]), .coreOut3Valid(srcV[3]),
      .asrcIn0Valid(srcV[4]), .asrcIn1Valid(srcV[5]), .dac0Sample(dac0Sample),
      .dac0Valid(dac0Valid), .dac1Sample(dac1Sample), .dac1Valid(dac1Valid),
      .pdm0Sample(pdm0Sample), .pdm0Valid(pdm0Valid), .pdm1Sample(pdm1Sample),
      .pdm1Valid(pdm1Valid), .badSelect(badSelect), .dacRoutePending(dacRoutePending));
   initial begin
      forever #4 ref_clk = ~ref_clk;
   end
   // Reserved codes are expected to give silence rather than a stale source.
   function automatic logic [23:0] ex(input logic [3:0] c);
      if (c < 4'h4) return src[c[1:0]];
      if (c == 4'hC) return src[4];
      if (c == 4'hD) return src[5];
      return 24'h000000;
   endfunction
   function automatic logic exv(input logic [3:0] c);
      if (c < 4'h4) return srcV[c[1:0]];
      if (c == 4'hC) return srcV[4];
      if (c == 4'hD) return srcV[5];
      return 1'b0;
   endfunction
   task chk(input logic [23:0] got, input logic [23:0] exp);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t: got %h, wanted %h", $time, got, exp);
      end
   endtask
   // The write strobe stays high until a later rd or outs call lowers it, so writes can follow each other with no gap.
   task wr(input logic [7:0] a, input logic [7:0] d);
      regWrite <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge ref_clk);
   endtask
   task rd(input logic [7:0] a, input logic [7:0] e);
      regWrite <= 1'b0;
      regRead <= 1'b1;
      regAddr <= a;
      @(posedge ref_clk);
      regRead <= 1'b0;
      @(negedge ref_clk);
      chk({16'h0000, regRdData}, {16'h0000, e});
      @(posedge ref_clk);
   endtask
   task outs(input logic [7:0] d, input logic [7:0] p);
      regWrite <= 1'b0;
      @(posedge ref_clk);
      @(negedge ref_clk);
      chk(dac0Sample, ex(d[3:0]));
      chk(dac1Sample, ex(d[7:4]));
      chk(pdm0Sample, ex(p[3:0]));
      chk(pdm1Sample, ex(p[7:4]));
      chk({23'h000000, dac0Valid}, {23'h000000, exv(d[3:0])});
      chk({23'h000000, dac1Valid}, {23'h000000, exv(d[7:4])});
      chk({23'h000000, pdm0Valid}, {23'h000000, exv(p[3:0])});
      chk({23'h000000, pdm1Valid}, {23'h000000, exv(p[7:4])});
      @(posedge ref_clk);
   endtask
   task test_done;
      $display("checks %0d, mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   initial begin
      #20000;
      n_fail++;
      test_done();
   end
   initial begin
      for (int i = 0; i < 6; i++) src[i] = 24'h111111 * (i + 1);
      repeat (3) @(posedge ref_clk);
      reset <= 1'b0;
      rd(8'h11, 8'h10);
      rd(8'h12, 8'h32);
      outs(8'h10, 8'h32);
      rd(8'h13, 8'h00);
      $display("reset values done");
      for (int i = 0; i < 6; i++) begin
         wr(8'h11, {codes[5-i], codes[i]});
         wr(8'h12, {codes[5-i], codes[i]});
         rd(8'h12, {codes[5-i], codes[i]});
         outs({codes[5-i], codes[i]}, {codes[5-i], codes[i]});
      end
      $display("select codes done");
      wr(8'h12, 8'h4F);
      outs(8'h0D, 8'h4F);
      @(negedge ref_clk);
      chk({20'h00000, badSelect}, 24'h00000C);
      chk({22'h000000, pdm1Valid, pdm0Valid}, 24'h000000);
      @(posedge ref_clk);
      $display("reserved code done");
      coreRunEnable <= 1'b1;
      wr(8'h11, 8'h23);
      rd(8'h11, 8'h23);
      outs(8'h0D, 8'h4F);
      @(negedge ref_clk);
      chk({23'h000000, dacRoutePending}, 24'h000001);
      @(posedge ref_clk);
      coreRunEnable <= 1'b0;
      repeat (2) @(posedge ref_clk);
      outs(8'h23, 8'h4F);
      @(negedge ref_clk);
      chk({23'h000000, dacRoutePending}, 24'h000000);
      @(posedge ref_clk);
      $display("run freeze done");
      reset <= 1'b1;
      repeat (3) @(posedge ref_clk);
      reset <= 1'b0;
      rd(8'h11, 8'h10);
      rd(8'h12, 8'h32);
      outs(8'h10, 8'h32);
      $display("mid-run reset done");
      test_done();
   end
endmodule
